// ===== design/fifo_size_word.sv
// One FIFO sizing word: depth in the upper half, start address in the lower half
`timescale 1ns/1ps
`include "usb_fifo_regs_defines.svh"
module fifo_size_word #(
    parameter logic [31:0] RESET_VALUE = `RST_IN_FIFO
) (
    input  wire logic                        clk,       // System clock
    input  wire logic                        rst_n,     // Async reset, active low
    input  wire logic                        writeHit,  // Write aimed at this word
    input  wire usb_fifo_regs_pkg::word_t    writeData, // Full word from software
    output usb_fifo_regs_pkg::word_t         value      // Stored word
);
    import usb_fifo_regs_pkg::*;

    // Whole word written at once; depth and start kept in their halves
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            value <= RESET_VALUE;
        end else if (writeHit) begin
            value <= writeData;
        end
    end
endmodule

// ===== design/usb_core_fifo_sizing_regs.sv
// Register bank: core identifier, FIFO sizing words and host clock choice
`timescale 1ns/1ps
`include "usb_fifo_regs_defines.svh"
module usb_core_fifo_sizing_regs #(
    parameter int IN_FIFOS = `IN_FIFO_COUNT
) (
    input  wire logic                           clk,            // 40 MHz system clock
    input  wire logic                           rst_n,          // Async reset, active low
    input  wire usb_fifo_regs_pkg::addr_t       addr,           // Byte address
    input  wire usb_fifo_regs_pkg::word_t       writeData,      // Write data
    input  wire logic                           writeStrobe,    // One-cycle write
    input  wire logic                           readStrobe,     // One-cycle read
    output usb_fifo_regs_pkg::word_t            readData,       // Data one cycle after read
    output usb_fifo_regs_pkg::clk_choice_t      usbClockChoice, // Selected USB clock code
    output logic                                usbClock48Sel,  // Clock choice is 48 MHz
    output logic                                depthInvalid    // Some depth out of range
);
    import usb_fifo_regs_pkg::*;

    word_t       coreIdentifier;
    word_t       hostPeriodicSize;
    clk_choice_t clockChoice;
    word_t       inFifoSize [IN_FIFOS];
    logic        inHit      [IN_FIFOS];
    logic        anyBadDepth;
    word_t       next_readData;

    // Index of the IN FIFO word addressed, or IN_FIFOS when none
    function automatic int inIndex(input addr_t a);
        int idx;
        idx = IN_FIFOS;
        for (int n = 0; n < IN_FIFOS; n++) begin
            if (a == addr_t'(`OFS_IN_FIFO_BASE + n * `OFS_IN_FIFO_STEP)) begin
                idx = n;
            end
        end
        return idx;
    endfunction

    // Depth field legal range check
    function automatic logic badDepth(input word_t w);
        return (w[`DEPTH_HI:`DEPTH_LO] == 16'h0000) ||
               (w[`DEPTH_HI:`DEPTH_LO] > `DEPTH_MAX);
    endfunction

    // Identifier word, whatever software last stored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            coreIdentifier <= `RST_CORE_ID;
        end else if (writeStrobe && addr == `OFS_CORE_ID) begin
            coreIdentifier <= writeData;
        end
    end

    // Host periodic FIFO sizing word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hostPeriodicSize <= `RST_HOST_PER_FIFO;
        end else if (writeStrobe && addr == `OFS_HOST_PER_FIFO) begin
            hostPeriodicSize <= writeData;
        end
    end

    // Host control: only the clock choice bits are stored, the rest read zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clockChoice <= clk_choice_t'(`RST_HOST_CONTROL);
        end else if (writeStrobe && addr == `OFS_HOST_CONTROL) begin
            clockChoice <= writeData[`CLK_CHOICE_HI:`CLK_CHOICE_LO];
        end
    end

    // IN endpoint FIFO sizing words
    generate
        for (genvar g = 0; g < IN_FIFOS; g++) begin : g_in
            assign inHit[g] = writeStrobe && (inIndex(addr) == g);
            fifo_size_word #(
                .RESET_VALUE (`RST_IN_FIFO)
            ) u_word (
                .clk       (clk),
                .rst_n     (rst_n),
                .writeHit  (inHit[g]),
                .writeData (writeData),
                .value     (inFifoSize[g])
            );
        end
    endgenerate

    // Read mux; unmapped addresses read zero
    always_comb begin
        int idx;
        idx = inIndex(addr);
        next_readData = 32'h0000_0000;
        if (addr == `OFS_CORE_ID) begin
            next_readData = coreIdentifier;
        end else if (addr == `OFS_HOST_PER_FIFO) begin
            next_readData = hostPeriodicSize;
        end else if (addr == `OFS_HOST_CONTROL) begin
            next_readData = {30'h0, clockChoice};
        end else if (idx < IN_FIFOS) begin
            next_readData = inFifoSize[idx];
        end
    end

    // Read data stands only in the cycle after the read strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readData <= 32'h0000_0000;
        end else if (readStrobe) begin
            readData <= next_readData;
        end else begin
            readData <= 32'h0000_0000;
        end
    end

    // Depth check across all sizing words
    always_comb begin
        anyBadDepth = badDepth(hostPeriodicSize);
        for (int n = 0; n < IN_FIFOS; n++) begin
            anyBadDepth = anyBadDepth | badDepth(inFifoSize[n]);
        end
    end

    // Registered status outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            usbClockChoice <= 2'h0;
            usbClock48Sel  <= 1'b0;
            depthInvalid   <= 1'b0;
        end else begin
            usbClockChoice <= clockChoice;
            usbClock48Sel  <= (clockChoice == `CLK_CHOICE_48MHZ);
            depthInvalid   <= anyBadDepth;
        end
    end

    // Identifier word takes a written value and reads it back
    property p_id_write;
        @(posedge clk) disable iff (!rst_n)
        (writeStrobe && addr == `OFS_CORE_ID) ##1 (readStrobe && addr == `OFS_CORE_ID)
            |=> readData == $past(writeData, 2);
    endproperty
    a_id_write: assert property (p_id_write) else $error("id word readback wrong");

    property p_host_fifo;
        @(posedge clk) disable iff (!rst_n)
        (writeStrobe && addr == `OFS_HOST_PER_FIFO) |=> hostPeriodicSize == $past(writeData);
    endproperty
    a_host_fifo: assert property (p_host_fifo) else $error("host fifo word not stored");

    property p_in_fifo0;
        @(posedge clk) disable iff (!rst_n)
        (writeStrobe && addr == `OFS_IN_FIFO_BASE) |=> inFifoSize[0] == $past(writeData);
    endproperty
    a_in_fifo0: assert property (p_in_fifo0) else $error("in fifo 1 not stored");

    property p_in_read;
        @(posedge clk) disable iff (!rst_n)
        (readStrobe && addr == `OFS_IN_FIFO_BASE + `OFS_IN_FIFO_STEP)
            |=> readData == inFifoSize[1];
    endproperty
    a_in_read: assert property (p_in_read) else $error("in fifo 2 read wrong");

    property p_ctl_reserved;
        @(posedge clk) disable iff (!rst_n)
        (readStrobe && addr == `OFS_HOST_CONTROL) |=> readData[31:2] == 30'h0000_0000;
    endproperty
    a_ctl_reserved: assert property (p_ctl_reserved) else $error("reserved bits nonzero");

    property p_clk48;
        @(posedge clk) disable iff (!rst_n)
        (writeStrobe && addr == `OFS_HOST_CONTROL && writeData[1:0] == 2'h1)
            |=> ##1 usbClock48Sel;
    endproperty
    a_clk48: assert property (p_clk48) else $error("48 MHz choice not flagged");

    property p_read_once;
        @(posedge clk) disable iff (!rst_n)
        !readStrobe |=> readData == 32'h0000_0000;
    endproperty
    a_read_once: assert property (p_read_once) else $error("read data outside its cycle");

    property p_depth;
        @(posedge clk) disable iff (!rst_n)
        (writeStrobe && addr == `OFS_HOST_PER_FIFO && writeData[31:16] == 16'h0000)
            |=> ##1 depthInvalid;
    endproperty
    a_depth: assert property (p_depth) else $error("zero depth not flagged");

    // Identifier word keeps its value between writes
    property p_id_hold;
        @(posedge clk) disable iff (!rst_n)
        !(writeStrobe && addr == `OFS_CORE_ID) |=> $stable(coreIdentifier);
    endproperty
    a_id_hold: assert property (p_id_hold) else $error("id word changed without a write");

    // Identifier read returns the stored word
    property p_id_read;
        @(posedge clk) disable iff (!rst_n)
        (readStrobe && addr == `OFS_CORE_ID) |=> readData == $past(coreIdentifier);
    endproperty
    a_id_read: assert property (p_id_read) else $error("id word read wrong");

    // Host periodic word keeps its value between writes
    property p_host_hold;
        @(posedge clk) disable iff (!rst_n)
        !(writeStrobe && addr == `OFS_HOST_PER_FIFO) |=> $stable(hostPeriodicSize);
    endproperty
    a_host_hold: assert property (p_host_hold) else $error("host fifo word changed");

    // Host periodic read returns depth and start as stored
    property p_host_read;
        @(posedge clk) disable iff (!rst_n)
        (readStrobe && addr == `OFS_HOST_PER_FIFO) |=> readData == $past(hostPeriodicSize);
    endproperty
    a_host_read: assert property (p_host_read) else $error("host fifo word read wrong");

    // Clock choice takes the 48 MHz code from a host control write
    property p_ctl_store;
        @(posedge clk) disable iff (!rst_n)
        (writeStrobe && addr == `OFS_HOST_CONTROL && writeData[1:0] == `CLK_CHOICE_48MHZ)
            |=> clockChoice == `CLK_CHOICE_48MHZ;
    endproperty
    a_ctl_store: assert property (p_ctl_store) else $error("clock choice not stored");

    // Clock choice keeps its value between host control writes
    property p_ctl_hold;
        @(posedge clk) disable iff (!rst_n)
        !(writeStrobe && addr == `OFS_HOST_CONTROL) |=> $stable(clockChoice);
    endproperty
    a_ctl_hold: assert property (p_ctl_hold) else $error("clock choice changed");

    // Host control read shows the stored clock choice in the low bits
    property p_ctl_read;
        @(posedge clk) disable iff (!rst_n)
        (readStrobe && addr == `OFS_HOST_CONTROL) |=> readData[1:0] == $past(clockChoice);
    endproperty
    a_ctl_read: assert property (p_ctl_read) else $error("clock choice read wrong");

    // Clock choice output trails the register by one cycle
    property p_choice_out;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> usbClockChoice == $past(clockChoice);
    endproperty
    a_choice_out: assert property (p_choice_out) else $error("clock choice output wrong");

    // The 48 MHz flag stays low for every other code
    property p_sel48_low;
        @(posedge clk) disable iff (!rst_n)
        (clockChoice != `CLK_CHOICE_48MHZ) |=> !usbClock48Sel;
    endproperty
    a_sel48_low: assert property (p_sel48_low) else $error("48 MHz flag without its code");

    // Oversized host depth reported two cycles after the write
    property p_depth_big;
        @(posedge clk) disable iff (!rst_n)
        (writeStrobe && addr == `OFS_HOST_PER_FIFO && writeData[31:16] > `DEPTH_MAX)
            |=> ##1 depthInvalid;
    endproperty
    a_depth_big: assert property (p_depth_big) else $error("large depth not flagged");

    // Zero depth in the second IN FIFO word reported two cycles after the write
    property p_depth_in;
        @(posedge clk) disable iff (!rst_n)
        (writeStrobe && addr == `OFS_IN_FIFO_BASE + `OFS_IN_FIFO_STEP && writeData[31:16] == 16'h0000)
            |=> ##1 depthInvalid;
    endproperty
    a_depth_in: assert property (p_depth_in) else $error("in fifo zero depth not flagged");

    // The word after the last IN FIFO is a hole and reads zero
    property p_hole_read;
        @(posedge clk) disable iff (!rst_n)
        (readStrobe && addr == addr_t'(`OFS_IN_FIFO_BASE + IN_FIFOS * `OFS_IN_FIFO_STEP))
            |=> readData == 32'h0000_0000;
    endproperty
    a_hole_read: assert property (p_hole_read) else $error("hole read not zero");

    // Each IN FIFO word stores its own writes and ignores all others
    generate
        for (genvar g = 0; g < IN_FIFOS; g++) begin : g_in_chk
            property p_in_write;
                @(posedge clk) disable iff (!rst_n)
                (writeStrobe && addr == addr_t'(`OFS_IN_FIFO_BASE + g * `OFS_IN_FIFO_STEP))
                    |=> inFifoSize[g] == $past(writeData);
            endproperty
            a_in_write: assert property (p_in_write) else $error("in fifo word not stored");
            property p_in_hold;
                @(posedge clk) disable iff (!rst_n)
                !(writeStrobe && addr == addr_t'(`OFS_IN_FIFO_BASE + g * `OFS_IN_FIFO_STEP))
                    |=> $stable(inFifoSize[g]);
            endproperty
            a_in_hold: assert property (p_in_hold) else $error("in fifo word changed");
        end
    endgenerate
endmodule

// ===== design/usb_fifo_regs_defines.svh
// Register offsets, field positions and reset values of the FIFO sizing bank
`ifndef USB_FIFO_REGS_DEFINES_SVH
`define USB_FIFO_REGS_DEFINES_SVH
`define ADDR_W             12
`define OFS_CORE_ID        12'h03C
`define OFS_HOST_PER_FIFO  12'h100
`define OFS_IN_FIFO_BASE   12'h104
`define OFS_IN_FIFO_STEP   12'h004
`define OFS_HOST_CONTROL   12'h400
`define RST_CORE_ID        32'h0000_0000 // Arbitrary identifier reset, names no part
`define RST_HOST_PER_FIFO  32'h0200_0600
`define RST_IN_FIFO        32'h0200_0400
`define RST_HOST_CONTROL   32'h0000_0000
`define DEPTH_HI           31
`define DEPTH_LO           16
`define START_HI           15
`define START_LO           0
`define CLK_CHOICE_HI      1
`define CLK_CHOICE_LO      0
`define CLK_CHOICE_48MHZ   2'h1
`define IN_FIFO_COUNT      3
`define DEPTH_MAX          16'h0400
`endif

// ===== design/usb_fifo_regs_pkg.sv
// Types shared by the FIFO sizing register bank
package usb_fifo_regs_pkg;
    typedef logic [11:0] addr_t;
    typedef logic [31:0] word_t;
    typedef logic [1:0]  clk_choice_t;
endpackage

// ===== dv/usb_core_fifo_sizing_regs_tb.sv
// Self-checking bench for the FIFO sizing register bank
`timescale 1ns/1ps
module usb_core_fifo_sizing_regs_tb;
    import usb_fifo_regs_pkg::*;
    logic        clk            = 1'b0;
    logic        rst_n          = 1'b0;
    addr_t       addr           = 12'h000;
    word_t       writeData      = 32'h0;
    logic        writeStrobe    = 1'b0;
    logic        readStrobe     = 1'b0;
    word_t       readData;
    clk_choice_t usbClockChoice;
    logic        usbClock48Sel;
    logic        depthInvalid;
    int          errorCnt       = 0;
    int          comparisons    = 0;
    int          cycles         = 0;
    // 40 MHz system clock
    always #12.5 clk = ~clk;
    usb_core_fifo_sizing_regs #(.IN_FIFOS(3)) dut (
        .clk(clk), .rst_n(rst_n), .addr(addr), .writeData(writeData),
        .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
        .usbClockChoice(usbClockChoice), .usbClock48Sel(usbClock48Sel),
        .depthInvalid(depthInvalid));
    // Cycle ceiling cuts a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errorCnt++;
            results();
        end
    end
    task automatic check(input string name, input word_t seen, input word_t exp);
        comparisons++;
        if (seen !== exp) begin
            errorCnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input addr_t a, input word_t d);
        @(posedge clk);
        addr <= a;
        writeData <= d;
        writeStrobe <= 1'b1;
        @(posedge clk);
        writeStrobe <= 1'b0;
    endtask
    // Read data are taken in the cycle after the strobe
    task automatic rdchk(input string name, input addr_t a, input word_t exp);
        @(posedge clk);
        addr <= a;
        readStrobe <= 1'b1;
        @(posedge clk);
        readStrobe <= 1'b0;
        #1;
        check(name, readData, exp);
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    // Reset values of every word and status output
    task automatic test_reset();
        rdchk("id", 12'h03C, 32'h0000_0000);
        rdchk("hostPer", 12'h100, 32'h0200_0600);
        for (int n = 0; n < 3; n++) rdchk("inFifo", 12'h104 + 12'(4 * n), 32'h0200_0400);
        rdchk("hostCtl", 12'h400, 32'h0000_0000);
        check("choice", {30'h0, usbClockChoice}, 32'h0);
        check("sel48", {31'h0, usbClock48Sel}, 32'h0);
        check("depthBad", {31'h0, depthInvalid}, 32'h0);
    endtask
    // Identifier word holds what software stored, read back one idle cycle after each write
    task automatic test_id();
        wr(12'h03C, 32'hA5C3_5A3C);
        rdchk("id", 12'h03C, 32'hA5C3_5A3C);
        @(posedge clk);
        #1;
        check("idle", readData, 32'h0);
        wr(12'h03C, 32'hFFFF_FFFF);
        rdchk("id", 12'h03C, 32'hFFFF_FFFF);
    endtask
    // Write then read of the identifier with no idle cycle between the strobes
    task automatic test_back_to_back();
        @(posedge clk);
        addr <= 12'h03C;
        writeData <= 32'h1234_5678;
        writeStrobe <= 1'b1;
        @(posedge clk);
        writeStrobe <= 1'b0;
        readStrobe <= 1'b1;
        @(posedge clk);
        readStrobe <= 1'b0;
        #1;
        check("idBackToBack", readData, 32'h1234_5678);
    endtask
    // Each sizing word decoded at its own offset, no aliasing, holes read zero
    task automatic test_fifo_words();
        wr(12'h100, 32'h0040_0000);
        for (int n = 0; n < 3; n++) begin
            wr(12'h104 + 12'(4 * n), {16'(n + 1), 16'h0040 + 16'(4 * n)});
        end
        wr(12'h110, 32'hDEAD_BEEF);
        rdchk("hostPer", 12'h100, 32'h0040_0000);
        for (int n = 0; n < 3; n++) begin
            rdchk("inFifo", 12'h104 + 12'(4 * n), {16'(n + 1), 16'h0040 + 16'(4 * n)});
        end
        rdchk("hole", 12'h110, 32'h0);
        rdchk("hole", 12'h0FC, 32'h0);
    endtask
    // Depth range ends flagged on each sizing kind while the other kind is legal
    task automatic test_depth();
        logic [15:0] depth[4] = '{16'h0000, 16'h0400, 16'h0401, 16'h0001};
        logic        bad[4]   = '{1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 4; i++) begin
            wr(12'h100, {depth[i], 16'h1000});
            settle();
            check("depthBad", {31'h0, depthInvalid}, {31'h0, bad[i]});
            wr(12'h100, 32'h0010_1000);
            wr(12'h108, {depth[i], 16'h1800});
            settle();
            check("depthBad", {31'h0, depthInvalid}, {31'h0, bad[i]});
            wr(12'h108, 32'h0010_0100);
        end
    endtask
    // Host control set once after reset to the 48 MHz code, reserved bits left zero
    task automatic test_host_control();
        wr(12'h400, 32'h0000_0001);
        rdchk("hostCtl", 12'h400, 32'h0000_0001);
        settle();
        check("choice", {30'h0, usbClockChoice}, 32'h1);
        check("sel48", {31'h0, usbClock48Sel}, 32'h1);
    endtask
    task automatic results();
        $display("Checks %0d mismatches %0d", comparisons, errorCnt);
        if (errorCnt == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        test_reset();
        test_host_control();
        test_id();
        test_back_to_back();
        test_fifo_words();
        test_depth();
        // Reset again mid-run: every word returns to its reset value
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        test_reset();
        results();
    end
endmodule
